// *** src/eai_consts.vh ***
`ifndef EAI_CONSTS_VH
`define EAI_CONSTS_VH
// =====================================================================
// Register map
`define EAI_ADR_W        12
`define EAI_OFF_EEPROM   12'h34C
`define EAI_OFF_EXPANDER 12'h350
`define EAI_OFF_IRQ_STAT 12'h380
`define EAI_OFF_IRQ_MASK 12'h384
// =====================================================================
// EEPROM access register fields
`define EAI_EE_ADDR_LSB  0
`define EAI_EE_ADDR_MSB  15
`define EAI_EE_DATA_LSB  16
`define EAI_EE_DATA_MSB  23
`define EAI_EE_BUSY_BIT  24
`define EAI_EE_DONE_BIT  25
`define EAI_EE_OP_BIT    26
`define EAI_EE_OP_WRITE  1'h0
`define EAI_EE_OP_READ   1'h1
// =====================================================================
// Expander register fields
`define EAI_EX_DATA_LSB  0
`define EAI_EX_DATA_MSB  15
`define EAI_EX_RELOAD    24
`define EAI_EX_TM_BIT    25
`define EAI_EX_SEL_LSB   26
`define EAI_EX_SEL_MSB   29
`define EAI_EX_DONE_BIT  31
`define EAI_SEL_IOE0     4'h0
`define EAI_SEL_IOE1     4'h1
`define EAI_SEL_IOE2     4'h2
`define EAI_SEL_IOE4     4'h4
`define EAI_IDX_IOE0     2'h0
`define EAI_IDX_IOE1     2'h1
`define EAI_IDX_IOE2     2'h2
`define EAI_IDX_IOE4     2'h3
// =====================================================================
// Interrupt status bits and reset values
`define EAI_IRQ_W        2
`define EAI_IRQ_EE       0
`define EAI_IRQ_EX       1
`define EAI_RST_ADDR     16'h0000
`define EAI_RST_BYTE     8'h00
`define EAI_RST_PINS     16'h0000
`define EAI_RST_SEL      4'h0
`define EAI_RST_WORD     32'h00000000
`endif

// *** src/eai_pin_bank.v ***
`timescale 1ns/100ps
`include "eai_consts.vh"
module eai_pin_bank #(
	parameter W  = 16,
	parameter D  = 4,
	parameter AW = 2
) (
	input  wire          clk_i,
	input  wire          rst_i,
	input  wire          wr_en_i,
	input  wire [AW-1:0] wr_idx_i,
	input  wire [W-1:0]  wr_data_i,
	input  wire [AW-1:0] rd_idx_i,
	output reg  [W-1:0]  rd_data_o
);
	// =================================================================
	// Storage of input pin values last read from each expander.
	wire [W*D-1:0] flat;
	genvar g;
	generate
		for (g = 0; g < D; g = g + 1) begin : g_ent
			reg [W-1:0] ent_r;
			always @(posedge clk_i) begin
				if (rst_i)
					ent_r <= `EAI_RST_PINS;
				else if (wr_en_i && wr_idx_i == g)
					ent_r <= wr_data_i;
			end
			assign flat[g*W +: W] = ent_r;
		end
	endgenerate
	always @(posedge clk_i) begin
		if (rst_i)
			rd_data_o <= `EAI_RST_PINS;
		else
			rd_data_o <= flat[rd_idx_i*W +: W];
	end
endmodule // eai_pin_bank

// *** src/eai_eeprom_ctl.v ***
`timescale 1ns/100ps
`include "eai_consts.vh"
module eai_eeprom_ctl (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        start_i,
	input  wire        rd_i,
	input  wire [15:0] addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        clr_done_i,
	input  wire        done_i,
	input  wire [7:0]  rdata_i,
	output reg         busy_o,
	output reg         done_o,
	output reg  [7:0]  data_o,
	output reg         req_o,
	output reg         rd_o,
	output reg  [15:0] addr_o,
	output reg  [7:0]  wdata_o
);
	// =================================================================
	// One operation at a time; a start while busy is ignored.
	wire go = start_i && !busy_o;
	always @(posedge clk_i) begin
		if (rst_i) begin
			busy_o  <= 1'b0;
			done_o  <= 1'b0;
			data_o  <= `EAI_RST_BYTE;
			req_o   <= 1'b0;
			rd_o    <= `EAI_EE_OP_WRITE;
			addr_o  <= `EAI_RST_ADDR;
			wdata_o <= `EAI_RST_BYTE;
		end else begin
			req_o <= go;
			if (go) begin
				busy_o  <= 1'b1; // [RULE5]
				rd_o    <= rd_i; // [RULE7]
				addr_o  <= addr_i; // [RULE1]
				wdata_o <= wdata_i; // [RULE3]
				if (rd_i == `EAI_EE_OP_WRITE)
					data_o <= wdata_i;
			end
			if (busy_o && done_i) begin
				busy_o <= 1'b0; // [RULE17]
				done_o <= 1'b1; // [RULE6]
				if (rd_o == `EAI_EE_OP_READ)
					data_o <= rdata_i; // [RULE4]
			end else if (clr_done_i) begin
				done_o <= 1'b0;
			end
		end
	end
endmodule // eai_eeprom_ctl

// *** src/eai_regs.v ***
`timescale 1ns/100ps
`include "eai_consts.vh"
// Functional notes
// [RULE1] Address field selects the EEPROM byte for the next operation.
// [RULE2] Writing the data byte launches one EEPROM read or write.
// [RULE3] On a write operation the written byte goes to the EEPROM.
// [RULE4] On a read the written byte is dropped; fetched byte shows when done.
// [RULE5] Busy bit is one while an EEPROM operation runs.
// [RULE6] Done bit sets on completion and clears on write of one.
// [RULE7] Operation select: zero writes, one reads.
// [RULE8] Expander data reads pin state of the selected expander.
// [RULE9] Expander data writes are ignored outside test mode.
// [RULE10] In test mode, written values drive the selected expander outputs.
// [RULE11] Expander input bits stay read-only, even in test mode.
// [RULE12] Writing one to reload starts a refresh of the expander.
// [RULE13] Reload bit always reads zero.
// [RULE14] Test mode bit is bit 25, read-write, reset zero.
// [RULE15] Select field codes 0, 1, 2, 4 pick expanders; others reserved.
// [RULE16] Expander done bit 31 sets on selected completion, write one clears.
// [RULE17] EEPROM completion clears busy and sets done in one cycle.
// [RULE18] Software starts an operation only when idle and done is cleared.
module eai_regs #(
	parameter NEXP    = 4,
	parameter PINS    = 16,
	parameter IN_MASK = 16'h00FF
) (
	input  wire                 clk_i,
	input  wire                 rst_i,
	input  wire                 wb_cyc_i,
	input  wire                 wb_stb_i,
	input  wire                 wb_we_i,
	input  wire [11:0]          wb_adr_i,
	input  wire [3:0]           wb_sel_i,
	input  wire [31:0]          wb_dat_i,
	output reg  [31:0]          wb_dat_o,
	output reg                  wb_ack_o,
	output reg                  irq_o,
	output wire                 ee_req_o,
	output wire                 ee_rd_o,
	output wire [15:0]          ee_addr_o,
	output wire [7:0]           ee_wdata_o,
	input  wire                 ee_done_i,
	input  wire [7:0]           ee_rdata_i,
	output reg                  exp_req_o,
	output reg                  exp_upd_o,
	output reg  [1:0]           exp_id_o,
	input  wire                 exp_done_i,
	input  wire [PINS-1:0]      exp_rdata_i,
	input  wire [NEXP*PINS-1:0] core_out_i,
	output reg  [NEXP*PINS-1:0] exp_out_o
);
	// =================================================================
	// Wishbone classic slave: ack one cycle after the request is seen.
	wire        req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        wr       = req && wb_we_i;
	wire        rd       = req && !wb_we_i;
	wire        hit_ee   = wb_adr_i[11:2] == `EAI_OFF_EEPROM >> 2;
	wire        hit_ex   = wb_adr_i[11:2] == `EAI_OFF_EXPANDER >> 2;
	wire        hit_st   = wb_adr_i[11:2] == `EAI_OFF_IRQ_STAT >> 2;
	wire        hit_mk   = wb_adr_i[11:2] == `EAI_OFF_IRQ_MASK >> 2;
	wire        wr_ee_lo = wr && hit_ee && wb_sel_i[0] && wb_sel_i[1];
	wire        wr_ee_dt = wr && hit_ee && wb_sel_i[2];
	wire        wr_ee_hi = wr && hit_ee && wb_sel_i[3];
	wire        wr_ex_lo = wr && hit_ex && wb_sel_i[0] && wb_sel_i[1];
	wire        wr_ex_hi = wr && hit_ex && wb_sel_i[3];

	// =================================================================
	// EEPROM access register.
	reg  [15:0] ee_addr_r;
	reg         ee_op_r;
	wire        ee_op_nxt;
	wire        ee_busy;
	wire        ee_done;
	wire [7:0]  ee_data;
	wire        ee_evt;

	assign ee_op_nxt = wr_ee_hi ? wb_dat_i[`EAI_EE_OP_BIT] : ee_op_r;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ee_addr_r <= `EAI_RST_ADDR;
			ee_op_r   <= `EAI_EE_OP_WRITE;
		end else begin
			if (wr_ee_lo)
				ee_addr_r <= wb_dat_i[`EAI_EE_ADDR_MSB:`EAI_EE_ADDR_LSB]; // [RULE1]
			if (wr_ee_hi)
				ee_op_r <= wb_dat_i[`EAI_EE_OP_BIT]; // [RULE7]
		end
	end

	// A start in the same write as a new address or operation uses the new ones.
	eai_eeprom_ctl u_ee (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.start_i    (wr_ee_dt), // [RULE2]
		.rd_i       (ee_op_nxt),
		.addr_i     (wr_ee_lo ? wb_dat_i[`EAI_EE_ADDR_MSB:`EAI_EE_ADDR_LSB] : ee_addr_r),
		.wdata_i    (wb_dat_i[`EAI_EE_DATA_MSB:`EAI_EE_DATA_LSB]),
		.clr_done_i (wr_ee_hi && wb_dat_i[`EAI_EE_DONE_BIT]), // [RULE6]
		.done_i     (ee_done_i),
		.rdata_i    (ee_rdata_i),
		.busy_o     (ee_busy),
		.done_o     (ee_done),
		.data_o     (ee_data),
		.req_o      (ee_req_o),
		.rd_o       (ee_rd_o),
		.addr_o     (ee_addr_o),
		.wdata_o    (ee_wdata_o)
	);

	assign ee_evt = ee_busy && ee_done_i;

	// =================================================================
	// Expander select decode; reserved codes disable the register.
	reg  [3:0]  ex_sel_r;
	reg         ex_tm_r;
	reg         ex_done_r;
	reg         ex_busy_r;
	reg  [1:0]  ex_idx;
	reg         ex_vld;
	wire [3:0]  ex_sel_nxt;
	wire        ex_tm_nxt;
	reg  [1:0]  ex_idx_nxt;
	reg         ex_vld_nxt;

	always @* begin
		ex_idx = `EAI_IDX_IOE0;
		ex_vld = 1'b1;
		case (ex_sel_r) // [RULE15]
			`EAI_SEL_IOE0: ex_idx = `EAI_IDX_IOE0;
			`EAI_SEL_IOE1: ex_idx = `EAI_IDX_IOE1;
			`EAI_SEL_IOE2: ex_idx = `EAI_IDX_IOE2;
			`EAI_SEL_IOE4: ex_idx = `EAI_IDX_IOE4;
			default:       ex_vld = 1'b0;
		endcase
	end

	assign ex_sel_nxt = wr_ex_hi ? wb_dat_i[`EAI_EX_SEL_MSB:`EAI_EX_SEL_LSB] : ex_sel_r;
	assign ex_tm_nxt  = wr_ex_hi ? wb_dat_i[`EAI_EX_TM_BIT] : ex_tm_r;

	always @* begin
		ex_idx_nxt = `EAI_IDX_IOE0;
		ex_vld_nxt = 1'b1;
		case (ex_sel_nxt)
			`EAI_SEL_IOE0: ex_idx_nxt = `EAI_IDX_IOE0;
			`EAI_SEL_IOE1: ex_idx_nxt = `EAI_IDX_IOE1;
			`EAI_SEL_IOE2: ex_idx_nxt = `EAI_IDX_IOE2;
			`EAI_SEL_IOE4: ex_idx_nxt = `EAI_IDX_IOE4;
			default:       ex_vld_nxt = 1'b0;
		endcase
	end

	// =================================================================
	// Expander transactions: a reload or a test-mode output update.
	wire ex_reload = wr_ex_hi && wb_dat_i[`EAI_EX_RELOAD] && ex_vld_nxt;
	wire ex_tmwr   = wr_ex_lo && ex_tm_nxt && ex_vld_nxt; // [RULE9]
	wire ex_go     = (ex_reload || ex_tmwr) && !ex_busy_r;
	wire ex_evt    = ex_busy_r && exp_done_i;
	wire ex_mine   = ex_evt && ex_vld && exp_id_o == ex_idx;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ex_sel_r  <= `EAI_RST_SEL;
			ex_tm_r   <= 1'b0;
			ex_done_r <= 1'b0;
			ex_busy_r <= 1'b0;
			exp_req_o <= 1'b0;
			exp_upd_o <= 1'b0;
			exp_id_o  <= `EAI_IDX_IOE0;
		end else begin
			ex_sel_r  <= ex_sel_nxt;
			ex_tm_r   <= ex_tm_nxt; // [RULE14]
			exp_req_o <= ex_go;
			if (ex_go) begin
				ex_busy_r <= 1'b1;
				exp_upd_o <= !ex_reload; // [RULE12]
				exp_id_o  <= ex_idx_nxt;
			end else if (ex_evt) begin
				ex_busy_r <= 1'b0;
			end
			if (ex_mine)
				ex_done_r <= 1'b1; // [RULE16]
			else if (wr_ex_hi && wb_dat_i[`EAI_EX_DONE_BIT])
				ex_done_r <= 1'b0;
		end
	end

	// =================================================================
	// Input values captured from each reload.
	wire [PINS-1:0] pin_in;

	eai_pin_bank #(
		.W  (PINS),
		.D  (NEXP),
		.AW (2)
	) u_bank (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (ex_evt && !exp_upd_o),
		.wr_idx_i  (exp_id_o),
		.wr_data_i (exp_rdata_i),
		.rd_idx_i  (ex_idx),
		.rd_data_o (pin_in)
	);

	// =================================================================
	// Output values: internal logic, or test values for the selected one.
	wire [NEXP*PINS-1:0] out_nxt;
	genvar g;
	generate
		for (g = 0; g < NEXP; g = g + 1) begin : g_exp
			reg  [PINS-1:0] tv_r;
			wire            on = ex_tm_r && ex_vld && ex_idx == g;
			always @(posedge clk_i) begin
				if (rst_i)
					tv_r <= `EAI_RST_PINS;
				else if (ex_tmwr && ex_idx_nxt == g)
					tv_r <= wb_dat_i[`EAI_EX_DATA_MSB:`EAI_EX_DATA_LSB] & ~IN_MASK; // [RULE11]
			end
			assign out_nxt[g*PINS +: PINS] = on ? tv_r : core_out_i[g*PINS +: PINS]; // [RULE10]
		end
	endgenerate

	always @(posedge clk_i) begin
		if (rst_i)
			exp_out_o <= {NEXP*PINS{1'b0}};
		else
			exp_out_o <= out_nxt;
	end

	wire [PINS-1:0] out_sel = exp_out_o[ex_idx*PINS +: PINS];
	wire [PINS-1:0] pin_view = ex_vld ? ((pin_in & IN_MASK) | (out_sel & ~IN_MASK))
	                                  : `EAI_RST_PINS; // [RULE8]

	// =================================================================
	// Interrupt status, cleared by a read; a new event wins over the clear.
	reg  [`EAI_IRQ_W-1:0] st_r;
	reg  [`EAI_IRQ_W-1:0] mk_r;
	reg  [`EAI_IRQ_W-1:0] st_nxt;
	wire [`EAI_IRQ_W-1:0] st_set;

	assign st_set = {ex_mine, ee_evt};

	always @* begin
		st_nxt = st_r;
		if (rd && hit_st)
			st_nxt = {`EAI_IRQ_W{1'b0}};
		st_nxt = st_nxt | st_set;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			st_r  <= {`EAI_IRQ_W{1'b0}};
			mk_r  <= {`EAI_IRQ_W{1'b0}};
			irq_o <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (wr && hit_mk && wb_sel_i[0])
				mk_r <= wb_dat_i[`EAI_IRQ_W-1:0];
			irq_o <= |(st_nxt & (wr && hit_mk && wb_sel_i[0] ?
			                     wb_dat_i[`EAI_IRQ_W-1:0] : mk_r));
		end
	end

	// =================================================================
	// Read data assembly; unmapped addresses read as zero.
	reg [31:0] rdat;

	always @* begin
		rdat = `EAI_RST_WORD;
		if (hit_ee) begin
			rdat[`EAI_EE_ADDR_MSB:`EAI_EE_ADDR_LSB] = ee_addr_r;
			rdat[`EAI_EE_DATA_MSB:`EAI_EE_DATA_LSB] = ee_data; // [RULE4]
			rdat[`EAI_EE_BUSY_BIT]                  = ee_busy; // [RULE5]
			rdat[`EAI_EE_DONE_BIT]                  = ee_done;
			rdat[`EAI_EE_OP_BIT]                    = ee_op_r;
		end else if (hit_ex) begin
			rdat[`EAI_EX_DATA_MSB:`EAI_EX_DATA_LSB] = pin_view;
			rdat[`EAI_EX_RELOAD]                    = 1'b0; // [RULE13]
			rdat[`EAI_EX_TM_BIT]                    = ex_tm_r;
			rdat[`EAI_EX_SEL_MSB:`EAI_EX_SEL_LSB]   = ex_sel_r;
			rdat[`EAI_EX_DONE_BIT]                  = ex_done_r;
		end else if (hit_st) begin
			rdat[`EAI_IRQ_W-1:0] = st_r;
		end else if (hit_mk) begin
			rdat[`EAI_IRQ_W-1:0] = mk_r;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `EAI_RST_WORD;
		end else begin
			wb_ack_o <= req;
			if (rd)
				wb_dat_o <= rdat;
		end
	end

endmodule // eai_regs

// *** tb/eai_regs_props.sv ***
`timescale 1ns/100ps
module eai_regs_props #(
	parameter NEXP = 4,
	parameter PINS = 16
) (
	input wire                 clk_i,
	input wire                 rst_i,
	input wire                 wb_cyc_i,
	input wire                 wb_stb_i,
	input wire                 wb_we_i,
	input wire [11:0]          wb_adr_i,
	input wire [3:0]           wb_sel_i,
	input wire [31:0]          wb_dat_i,
	input wire [31:0]          wb_dat_o,
	input wire                 wb_ack_o,
	input wire                 ee_req_o,
	input wire                 ee_rd_o,
	input wire [15:0]          ee_addr_o,
	input wire [7:0]           ee_wdata_o,
	input wire                 ee_done_i,
	input wire                 exp_req_o,
	input wire                 exp_upd_o,
	input wire [1:0]           exp_id_o,
	input wire                 exp_done_i,
	input wire [NEXP*PINS-1:0] core_out_i,
	input wire [NEXP*PINS-1:0] exp_out_o
);
// ==========
// Shadow of the busy and test-mode state.
wire take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire ee_wr = take && wb_we_i && wb_adr_i[11:2] == 10'h0D3 && wb_sel_i[2];
wire ex_wr = take && wb_we_i && wb_adr_i[11:2] == 10'h0D4 && wb_sel_i[3];
wire ex_rd = take && !wb_we_i && wb_adr_i[11:2] == 10'h0D4;
reg  ee_busy_r;
reg  ex_busy_r;
reg  tm_r;
always @(posedge clk_i) begin
	if (rst_i) begin
		ee_busy_r <= 1'b0;
		ex_busy_r <= 1'b0;
		tm_r      <= 1'b0;
	end else begin
		ee_busy_r <= ee_req_o | (ee_busy_r & ~ee_done_i);
		ex_busy_r <= exp_req_o | (ex_busy_r & ~exp_done_i);
		if (ex_wr)
			tm_r <= wb_dat_i[25];
	end
end
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
launch_a: assert property (ee_req_o == ($past(ee_wr) && !$past(ee_busy_r)))
	else $error("eeprom start mismatch");
wbyte_a: assert property (ee_req_o |-> ee_wdata_o == $past(wb_dat_i[23:16]))
	else $error("eeprom byte mismatch");
opsel_a: assert property (ee_req_o && $past(wb_sel_i[3])
	|-> ee_rd_o == $past(wb_dat_i[26])) else $error("eeprom op mismatch");
addr_a: assert property (ee_req_o && $past(wb_sel_i[1:0]) == 2'h3
	|-> ee_addr_o == $past(wb_dat_i[15:0])) else $error("eeprom address mismatch");
hold_a: assert property (!ee_req_o && !$past(rst_i)
	|-> $stable({ee_rd_o, ee_addr_o, ee_wdata_o})) else $error("eeprom request moved");
reload_zero_a: assert property (wb_ack_o && $past(ex_rd) |-> !wb_dat_o[24])
	else $error("reload bit read one");
reload_go_a: assert property (ex_wr && wb_dat_i[24] && !wb_dat_i[25]
	&& wb_dat_i[29:26] == 4'h4 && !ex_busy_r
	|=> exp_req_o && !exp_upd_o && exp_id_o == 2'h3) else $error("reload not started");
reserved_a: assert property (ex_wr && wb_dat_i[29:26] == 4'h3 |=> !exp_req_o)
	else $error("reserved select started a transfer");
core_out_a: assert property (!tm_r && !ex_wr |=> exp_out_o == $past(core_out_i))
	else $error("outputs not from core");
endmodule // eai_regs_props
bind eai_regs eai_regs_props #(.NEXP(NEXP), .PINS(PINS)) u_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ee_req_o(ee_req_o), .ee_rd_o(ee_rd_o),
	.ee_addr_o(ee_addr_o), .ee_wdata_o(ee_wdata_o), .ee_done_i(ee_done_i),
	.exp_req_o(exp_req_o), .exp_upd_o(exp_upd_o), .exp_id_o(exp_id_o),
	.exp_done_i(exp_done_i), .core_out_i(core_out_i), .exp_out_o(exp_out_o));

// *** tb/eai_smb_model.sv ***
`timescale 1ns/100ps
module eai_smb_model (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [7:0]  lat_i,
	input  wire        ee_req_i,
	input  wire        ee_rd_i,
	input  wire [15:0] ee_addr_i,
	input  wire [7:0]  ee_wdata_i,
	output reg         ee_done_o,
	output reg  [7:0]  ee_rdata_o,
	input  wire        exp_req_i,
	input  wire [1:0]  exp_id_i,
	output reg         exp_done_o,
	output reg  [15:0] exp_rdata_o
);
// ==========
// Answers after lat_i cycles; data lines toggle when not valid.
reg [7:0] mem_r [0:255];
reg [7:0] ee_cnt_r;
reg [7:0] ex_cnt_r;
always @(posedge clk_i) begin
	ee_done_o   <= 1'b0;
	exp_done_o  <= 1'b0;
	ee_rdata_o  <= ~ee_rdata_o;
	exp_rdata_o <= ~exp_rdata_o;
	if (rst_i) begin
		ee_cnt_r    <= 8'h00;
		ex_cnt_r    <= 8'h00;
		ee_rdata_o  <= 8'h5A;
		exp_rdata_o <= 16'h5AA5;
	end else begin
		if (ee_req_i)
			ee_cnt_r <= lat_i;
		else if (ee_cnt_r != 8'h00)
			ee_cnt_r <= ee_cnt_r - 8'h01;
		if (!ee_req_i && ee_cnt_r == 8'h01) begin
			ee_done_o <= 1'b1;
			if (ee_rd_i)
				ee_rdata_o <= mem_r[ee_addr_i[7:0]];
			else
				mem_r[ee_addr_i[7:0]] <= ee_wdata_i;
		end
		if (exp_req_i)
			ex_cnt_r <= lat_i;
		else if (ex_cnt_r != 8'h00)
			ex_cnt_r <= ex_cnt_r - 8'h01;
		if (!exp_req_i && ex_cnt_r == 8'h01) begin
			exp_done_o  <= 1'b1;
			exp_rdata_o <= {8'hA5, 6'h0C, exp_id_i};
		end
	end
end
endmodule // eai_smb_model

// *** tb/eai_regs_tb_top.sv ***
`timescale 1ns/100ps
module eai_regs_tb_top;
reg         clk_i = 1'b0;
reg         rst_i = 1'b1;
reg         cyc = 1'b0;
reg         stb = 1'b0;
reg         we = 1'b0;
reg  [11:0] adr = 12'h000;
reg  [3:0]  sel = 4'h0;
reg  [31:0] dat = 32'h00000000;
reg  [63:0] core = 64'h9966778855443322;
reg  [7:0]  lat = 8'h14;
reg  [31:0] rd;
wire [31:0] wb_dat_o;
wire        wb_ack_o, irq_o, ee_req_o, ee_rd_o, ee_done_i, exp_req_o, exp_done_i;
wire [15:0] ee_addr_o, exp_rdata_i;
wire [7:0]  ee_wdata_o, ee_rdata_i;
wire [1:0]  exp_id_o;
wire [63:0] exp_out_o;
integer     n_errors = 0;
integer     n_checks = 0;
integer     n_req = 0;
integer     n_xreq = 0;
always #5 clk_i = ~clk_i;
always @(posedge clk_i) begin
	n_req  <= n_req + ee_req_o;
	n_xreq <= n_xreq + exp_req_o;
end
eai_regs #(.NEXP(4), .PINS(16), .IN_MASK(16'h00FF)) DUT (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
	.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .irq_o(irq_o), .ee_req_o(ee_req_o), .ee_rd_o(ee_rd_o),
	.ee_addr_o(ee_addr_o), .ee_wdata_o(ee_wdata_o), .ee_done_i(ee_done_i),
	.ee_rdata_i(ee_rdata_i), .exp_req_o(exp_req_o), .exp_upd_o(),
	.exp_id_o(exp_id_o), .exp_done_i(exp_done_i), .exp_rdata_i(exp_rdata_i),
	.core_out_i(core), .exp_out_o(exp_out_o));
eai_smb_model mdl (
	.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .ee_req_i(ee_req_o),
	.ee_rd_i(ee_rd_o), .ee_addr_i(ee_addr_o), .ee_wdata_i(ee_wdata_o),
	.ee_done_o(ee_done_i), .ee_rdata_o(ee_rdata_i), .exp_req_i(exp_req_o),
	.exp_id_i(exp_id_o), .exp_done_o(exp_done_i), .exp_rdata_o(exp_rdata_i));
task check(input [31:0] seen, input [31:0] exp);
	begin
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	end
endtask
task wb(input w, input [11:0] a, input [3:0] s, input [31:0] d);
	begin
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	end
endtask
task wait_irq;
	integer i;
	begin
		i = 0;
		while (irq_o !== 1'b1 && i < 200) begin
			@(posedge clk_i);
			i = i + 1;
		end
		check(irq_o, 1);
	end
endtask
task t_reset;
	begin
		wb(0, 12'h34C, 4'hF, 0);
		check(rd, 0);
		wb(0, 12'h350, 4'hF, 0);
		check(rd, 32'h00003300);
		wb(1, 12'h3FC, 4'hF, 32'hFFFFFFFF);
		wb(0, 12'h3FC, 4'hF, 0);
		check(rd, 0);
		wb(1, 12'h384, 4'hF, 32'h00000003);
		$display("test reset done");
	end
endtask
task t_ee_write;
	begin
		wb(1, 12'h34C, 4'hF, 32'h00A50012);
		wb(0, 12'h34C, 4'hF, 0);
		check(rd, 32'h01A50012);
		wb(1, 12'h34C, 4'h4, 32'h00770000);
		wait_irq;
		check(n_req, 1);
		check(mdl.mem_r[8'h12], 8'hA5);
		wb(0, 12'h34C, 4'hF, 0);
		check(rd, 32'h02A50012);
		wb(0, 12'h380, 4'hF, 0);
		check(rd, 1);
		wb(1, 12'h34C, 4'h8, 32'h02000000);
		check(irq_o, 0);
		wb(0, 12'h34C, 4'hF, 0);
		check(rd, 32'h00A50012);
		$display("test eeprom write done");
	end
endtask
task t_ee_read;
	begin
		lat <= 8'h01;
		wb(0, 12'h34C, 4'hF, 0);
		check(rd[25:24], 0);
		wb(1, 12'h384, 4'hF, 32'h00000002);
		wb(1, 12'h34C, 4'hF, 32'h04FF0012);
		wb(0, 12'h34C, 4'hF, 0);
		wb(0, 12'h34C, 4'hF, 0);
		check(irq_o, 0);
		check(ee_rd_o, 1);
		wb(1, 12'h384, 4'hF, 32'h00000003);
		wait_irq;
		wb(0, 12'h34C, 4'hF, 0);
		check(rd, 32'h06A50012);
		wb(0, 12'h380, 4'hF, 0);
		wb(1, 12'h34C, 4'h8, 32'h06000000);
		check(n_req, 2);
		$display("test eeprom read done");
	end
endtask
task t_expander;
	begin
		lat <= 8'h06;
		wb(1, 12'h350, 4'hF, 32'h11000000);
		wait_irq;
		wb(0, 12'h350, 4'hF, 0);
		check(rd, 32'h90009933);
		wb(0, 12'h380, 4'hF, 0);
		wb(1, 12'h350, 4'h8, 32'h90000000);
		wb(1, 12'h350, 4'hF, 32'h1000FFFF);
		wb(0, 12'h350, 4'hF, 0);
		check(rd, 32'h10009933);
		check(n_xreq, 1);
		wb(1, 12'h350, 4'hF, 32'h1200ABCD);
		wait_irq;
		check(exp_out_o[63:56], 8'hAB);
		check(exp_out_o[31:0], core[31:0]);
		wb(0, 12'h350, 4'hF, 0);
		check(rd, 32'h9200AB33);
		wb(0, 12'h380, 4'hF, 0);
		wb(1, 12'h350, 4'h8, 32'h10000000);
		wb(1, 12'h350, 4'h8, 32'h0D000000);
		wb(0, 12'h350, 4'hF, 0);
		check(rd[15:0], 0);
		check(n_xreq, 2);
		check(exp_out_o[63:32], core[63:32]);
		$display("test expander done");
	end
endtask
task give_verdict;
	begin
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
endtask
initial begin
	repeat (5000) @(posedge clk_i);
	n_errors = n_errors + 1;
	give_verdict;
end
initial begin
	repeat (10) @(posedge clk_i);
	rst_i <= 1'b0;
	t_reset;
	t_ee_write;
	t_ee_read;
	t_expander;
	give_verdict;
end
endmodule // eai_regs_tb_top
